// File: dual_timer_defs.vh
`ifndef DUAL_TIMER_DEFS_VH
`define DUAL_TIMER_DEFS_VH

// register byte offsets
`define OFF_CTRL        12'h000
`define OFF_RELOAD0     12'h004
`define OFF_RELOAD1     12'h008
`define OFF_CNT0_LOW    12'h00c
`define OFF_CNT0_HIGH   12'h010
`define OFF_CNT1_LOW    12'h014
`define OFF_CNT1_HIGH   12'h018
`define OFF_PORT        12'h01c
`define OFF_IRQ_FLAG    12'h020
`define OFF_IRQ_MASK    12'h024
`define OFF_STATUS      12'h028

// control register fields
`define CTRL_RUN0       0
`define CTRL_RUN1       1
`define CTRL_WAVE_EN    2
`define CTRL_FAST_ON    3
`define CTRL_SRC0_LO    4
`define CTRL_SRC0_HI    5
`define CTRL_SRC1_LO    6
`define CTRL_SRC1_HI    7
`define CTRL_RST        8'h00

// clock source select codes
`define SRC_SLOW        2'b00
`define SRC_FAST        2'b01
`define SRC_EVENT       2'b10

// port register fields: data in [3:0], hi-z in [7:4], special select in [11:8]
`define PORT_RST        12'h00f

// timing: slow tick 32.768 kHz, fast tick 4 MHz from a 125 MHz clock
`define CLK_HZ          125000000
`define SLOW_HZ         32768
`define FAST_HZ         4000000
`define SLOW_DIV        (`CLK_HZ / `SLOW_HZ)
`define FAST_DIV        (`CLK_HZ / `FAST_HZ)

`endif

// File: tick_divider.v
`timescale 1ns/10ps
`default_nettype none

// one-cycle enable pulse every DIV cycles while enabled
module tick_divider #(
    parameter DIV = 16
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        enable,
    output reg         tick
);
    reg [15:0] count;

    // free counter, held cleared while disabled
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= 16'h0000;
            tick  <= 1'b0;
        end else if (!enable) begin
            count <= 16'h0000;
            tick  <= 1'b0;
        end else if (count == DIV[15:0] - 16'h0001) begin
            count <= 16'h0000;
            tick  <= 1'b1;
        end else begin
            count <= count + 16'h0001;
            tick  <= 1'b0;
        end
    end
endmodule // tick_divider

`default_nettype wire

// File: timer_channel.v
`timescale 1ns/10ps
`default_nettype none

// one 8-bit down counter with edge-synchronised run/stop
module timer_channel (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        clk_fall,
    input  wire        run_req,
    input  wire [7:0]  reload,
    output reg  [7:0]  count,
    output reg         running,
    output reg         underflow,
    output reg         wave
);
    // run state only follows the request on the input clock's falling edge;
    // a stop lands together with the decrement on that same edge
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count     <= 8'h00;
            running   <= 1'b0;
            underflow <= 1'b0;
            wave      <= 1'b0;
        end else begin
            underflow <= 1'b0;
            if (clk_fall) begin
                running <= run_req;
                if (running) begin
                    if (count == 8'h00) begin
                        count     <= reload;
                        underflow <= 1'b1;
                        wave      <= ~wave;
                    end else begin
                        count <= count - 8'h01;
                    end
                end else if (run_req) begin
                    count <= reload;
                end
            end
        end
    end
endmodule // timer_channel

`default_nettype wire

// File: dual_down_counting_timer.v
`timescale 1ns/10ps
`default_nettype none
`include "dual_timer_defs.vh"

// Notes on behaviour
// - run control acts on next input falling edge
// - stop happens together with the next decrement
// - run bit reads 1 until truly stopped
// - event mode: no edge, state unchanged
// - wave output may glitch on enable toggle
// - fast oscillator off after reset
// - event pin feeds port and timer both
// - data 0 forces pin low
// - hi-z 1 floats pin always
// - irq flag sets regardless of mask
// - irq flag cleared by writing one
module dual_down_counting_timer (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [11:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire        event_clock_pin,
    output reg         event_pin_level,
    output reg  [3:0]  port_out,
    output reg  [3:0]  port_oe,
    output reg         irq
);
    reg  [7:0]  ctrl;
    reg  [7:0]  reload0;
    reg  [7:0]  reload1;
    reg  [11:0] port_reg;
    reg  [1:0]  timer_irq_flag;
    reg  [1:0]  timer_irq_mask;
    reg  [3:0]  timer0_count_high;
    reg  [3:0]  timer1_count_high;
    reg         ev_prev;
    reg         wr_pend;
    reg  [11:0] wr_addr;
    reg         slow_prev;
    reg         fast_prev;
    reg         slow_level;
    reg         fast_level;

    wire        slow_tick;
    wire        fast_tick;
    wire        ev_fall;
    wire        slow_fall;
    wire        fast_fall;
    wire [7:0]  cnt0;
    wire [7:0]  cnt1;
    wire        run0;
    wire        run1;
    wire        uf0;
    wire        uf1;
    wire        wave0;
    wire        wave1;
    wire        clk_fall0;
    wire        clk_fall1;
    wire        rd_req;
    wire [1:0]  irq_set;
    wire [3:0]  timer_wave_signal;
    reg  [31:0] rd_data;
    wire [3:0]  next_port_out;
    wire [3:0]  next_port_oe;

    // register map, one word each:
    //   0x00 control: run0, run1, wave enable, fast on, two source codes
    //   0x04 / 0x08 reload values of timer 0 / timer 1
    //   0x0c / 0x10 timer 0 count, low then latched high nibble
    //   0x14 / 0x18 timer 1 count, low then latched high nibble
    //   0x1c pins: data [3:0], hi-z [7:4], special select [11:8]
    //   0x20 interrupt flags, write one to clear
    //   0x24 interrupt masks
    //   0x28 status: run0, run1, event pin level
    // source codes: 00 slow, 01 fast, 10 event pin, 11 no clock

    // select the falling edge of the chosen clock source
    function src_fall;
        input [1:0] sel;
        input       slow_f;
        input       fast_f;
        input       ev_f;
        begin
            case (sel)
                `SRC_SLOW:  src_fall = slow_f;
                `SRC_FAST:  src_fall = fast_f;
                `SRC_EVENT: src_fall = ev_f;
                default:    src_fall = 1'b0;
            endcase
        end
    endfunction

    // software view of a run bit: stays 1 until the channel has truly stopped
    function run_view;
        input written;
        input counting;
        begin
            run_view = written | counting;
        end
    endfunction

    // one word compare for the address map, shared by reads and writes
    function addr_is;
        input [11:0] addr;
        input [11:0] offset;
        begin
            addr_is = (addr == offset);
        end
    endfunction

    // slow divider free-runs: the slow clock never stops
    // fast divider only runs while the fast oscillator is switched on,
    // so no fast fall can reach a timer straight after reset
    tick_divider #(.DIV(`SLOW_DIV / 2)) u_slow (
        .hclk    (hclk),
        .hresetn (hresetn),
        .enable  (1'b1),
        .tick    (slow_tick)
    );

    tick_divider #(.DIV(`FAST_DIV / 2)) u_fast (
        .hclk    (hclk),
        .hresetn (hresetn),
        .enable  (ctrl[`CTRL_FAST_ON]),
        .tick    (fast_tick)
    );

    // half-period ticks toggle internal square clocks; falls are one-cycle pulses
    // pin and internal clocks idle low, so no false fall follows reset
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slow_level <= 1'b0;
            fast_level <= 1'b0;
            slow_prev  <= 1'b0;
            fast_prev  <= 1'b0;
            ev_prev    <= 1'b0;
        end else begin
            if (slow_tick)
                slow_level <= ~slow_level;
            if (fast_tick)
                fast_level <= ~fast_level;
            slow_prev <= slow_level;
            fast_prev <= fast_level;
            ev_prev   <= event_clock_pin;
        end
    end

    assign slow_fall = slow_prev & ~slow_level;
    assign fast_fall = fast_prev & ~fast_level;
    assign ev_fall   = ev_prev & ~event_clock_pin;
    assign clk_fall0 = src_fall(ctrl[`CTRL_SRC0_HI:`CTRL_SRC0_LO], slow_fall, fast_fall, ev_fall);
    assign clk_fall1 = src_fall(ctrl[`CTRL_SRC1_HI:`CTRL_SRC1_LO], slow_fall, fast_fall, ev_fall);

    // the two timers share one body; run and stop land on the chosen
    // clock's fall, and a stop still takes that edge's decrement
    // timer 0: irq flag bit 0, wave on pin lanes 0 and 2
    timer_channel u_t0 (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .clk_fall  (clk_fall0),
        .run_req   (ctrl[`CTRL_RUN0]),
        .reload    (reload0),
        .count     (cnt0),
        .running   (run0),
        .underflow (uf0),
        .wave      (wave0)
    );

    // timer 1: irq flag bit 1, wave on pin lanes 1 and 3
    timer_channel u_t1 (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .clk_fall  (clk_fall1),
        .run_req   (ctrl[`CTRL_RUN1]),
        .reload    (reload1),
        .count     (cnt1),
        .running   (run1),
        .underflow (uf1),
        .wave      (wave1)
    );

    // pin level also goes to the general input port, whatever the timer source;
    // its input-port interrupt logic keeps seeing the pin in timer use
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            event_pin_level <= 1'b0;
        else
            event_pin_level <= event_clock_pin;
    end

    // ahb-lite address phase capture; always zero wait state, always okay
    // hsize is ignored: every register is one whole word
    assign rd_req = hsel & hready & htrans[1] & ~hwrite;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend   <= 1'b0;
            wr_addr   <= 12'h000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend   <= hsel & hready & htrans[1] & hwrite;
            wr_addr   <= haddr;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // timer underflow raises its flag whatever the mask says
    assign irq_set = {uf1, uf0};

    // register writes in the data phase; set beats the write-one clear
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl           <= `CTRL_RST;
            reload0        <= 8'h00;
            reload1        <= 8'h00;
            port_reg       <= `PORT_RST;
            timer_irq_flag <= 2'b00;
            timer_irq_mask <= 2'b00;
        end else begin
            if (wr_pend) begin
                case (wr_addr)
                    `OFF_CTRL:     ctrl           <= hwdata[7:0];
                    `OFF_RELOAD0:  reload0        <= hwdata[7:0];
                    `OFF_RELOAD1:  reload1        <= hwdata[7:0];
                    `OFF_PORT:     port_reg       <= hwdata[11:0];
                    `OFF_IRQ_MASK: timer_irq_mask <= hwdata[1:0];
                    default: ;
                endcase
            end
            // only bits written as one clear; an underflow in the same cycle keeps its bit
            if (wr_pend && addr_is(wr_addr, `OFF_IRQ_FLAG))
                timer_irq_flag <= (timer_irq_flag & ~hwdata[1:0]) | irq_set;
            else
                timer_irq_flag <= timer_irq_flag | irq_set;
        end
    end

    // reading a low nibble freezes the matching high nibble;
    // a second low read before the high read refreshes the frozen value
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer0_count_high <= 4'h0;
            timer1_count_high <= 4'h0;
        end else begin
            if (rd_req && addr_is(haddr, `OFF_CNT0_LOW))
                timer0_count_high <= cnt0[7:4];
            if (rd_req && addr_is(haddr, `OFF_CNT1_LOW))
                timer1_count_high <= cnt1[7:4];
        end
    end

    // read mux; run bits show 1 until the channel has truly stopped
    // unmapped words read zero
    always @* begin
        rd_data = 32'h00000000;
        case (haddr)
            `OFF_CTRL:      rd_data = {24'h000000, ctrl[7:2],
                                       run_view(ctrl[`CTRL_RUN1], run1),
                                       run_view(ctrl[`CTRL_RUN0], run0)};
            `OFF_RELOAD0:   rd_data = {24'h000000, reload0};
            `OFF_RELOAD1:   rd_data = {24'h000000, reload1};
            `OFF_CNT0_LOW:  rd_data = {28'h0000000, cnt0[3:0]};
            `OFF_CNT0_HIGH: rd_data = {28'h0000000, timer0_count_high};
            `OFF_CNT1_LOW:  rd_data = {28'h0000000, cnt1[3:0]};
            `OFF_CNT1_HIGH: rd_data = {28'h0000000, timer1_count_high};
            `OFF_PORT:      rd_data = {20'h00000, port_reg};
            `OFF_IRQ_FLAG:  rd_data = {30'h00000000, timer_irq_flag};
            `OFF_IRQ_MASK:  rd_data = {30'h00000000, timer_irq_mask};
            `OFF_STATUS:    rd_data = {29'h00000000, event_pin_level, run1, run0};
            default:        rd_data = 32'h00000000;
        endcase
    end

    // read data is taken at the address edge and held until the next read;
    // a read right behind a write's data phase still sees the old word
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (rd_req)
            hrdata <= rd_data;
    end

    // wave gating is a plain and; the enable is not aligned to the wave
    // so a toggle may clip up to half a wave period
    assign timer_wave_signal = {wave1, wave0, wave1, wave0} &
                               {4{ctrl[`CTRL_WAVE_EN]}};

    // pin drive, one lane at a time: hi-z wins, then data 0 forces low,
    // else the special wave or the data bit
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane = lane + 1) begin : g_pin
            assign next_port_oe[lane]  = ~port_reg[4 + lane];
            assign next_port_out[lane] = port_reg[lane] &
                                         (~port_reg[8 + lane] | timer_wave_signal[lane]);
        end
    endgenerate

    // outputs straight from flops; irq level while any unmasked flag set
    // irq trails a flag or mask change by one cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_out <= 4'h0;
            port_oe  <= 4'h0;
            irq      <= 1'b0;
        end else begin
            port_out <= next_port_out;
            port_oe  <= next_port_oe;
            irq      <= |(timer_irq_flag & timer_irq_mask);
        end
    end
endmodule // dual_down_counting_timer

`default_nettype wire

// File: dual_timer_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "dual_timer_defs.vh"
module dual_timer_checker (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        event_clock_pin,
    input wire logic        event_pin_level,
    input wire logic [3:0]  port_out,
    input wire logic [3:0]  port_oe,
    input wire logic        irq
);
    logic        take;
    logic        port_wr;
    logic        mask_wr;
    logic [11:0] port_cap;

    // accepted address phase
    assign take = hsel & hready & htrans[1];

    // data-phase markers; port data kept since pins lag two edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_wr  <= 1'b0;
            mask_wr  <= 1'b0;
            port_cap <= 12'h000;
        end else begin
            port_wr  <= take & hwrite & (haddr == `OFF_PORT);
            mask_wr  <= take & hwrite & (haddr == `OFF_IRQ_MASK);
            if (port_wr) begin
                port_cap <= hwdata[11:0];
            end
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    okay_resp_a: assert property (hresp == 1'b0)
        else $error("error response seen");
    ready_high_a: assert property (hreadyout == 1'b1)
        else $error("wait state inserted");
    pin_copy_a: assert property (event_pin_level == $past(event_clock_pin))
        else $error("pin level copy lost");
    port_enable_a: assert property (port_wr |-> ##2 port_oe == ~port_cap[7:4])
        else $error("pin enable ignores hi-z bits");
    port_value_a: assert property (port_wr |-> ##2
        ((port_out ^ port_cap[3:0]) & ~port_cap[7:4] & ~(port_cap[11:8] & port_cap[3:0])) == 4'h0)
        else $error("pin level not data");
    irq_masked_a: assert property ((mask_wr && hwdata[1:0] == 2'b00) |-> ##2 !irq [*3])
        else $error("interrupt with all masked");
    reset_port_a: assert property ($rose(hresetn) |=> port_oe == 4'hf && port_out == 4'hf)
        else $error("pins not driven high after reset");
    rdata_hold_a: assert property (!(take && !hwrite) |=> $stable(hrdata))
        else $error("read data moved without read");

    // main scenarios reached
    cover property (port_wr);
    cover property ($rose(irq));
    cover property (mask_wr);
endmodule // dual_timer_checker

bind dual_down_counting_timer dual_timer_checker dual_timer_checker_i (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .event_clock_pin, .event_pin_level, .port_out, .port_oe, .irq
);
`default_nettype wire

// File: dual_down_counting_timer_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "dual_timer_defs.vh"
module dual_down_counting_timer_tb;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        event_clock_pin;
    logic        event_pin_level;
    logic [3:0]  port_out;
    logic [3:0]  port_oe;
    logic        irq;
    logic [31:0] rd;
    logic [7:0]  rel;
    logic [7:0]  cnt;
    logic [11:0] pv;
    logic [3:0]  m;
    int          num_errors;
    int          samples_checked;

    dual_down_counting_timer dual_down_counting_timer_i (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .event_clock_pin,
        .event_pin_level, .port_out, .port_oe, .irq
    );

    task automatic complete_run;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // expected pin drive: data 0 forces low, special lanes show the wave
    function automatic logic [3:0] exp_out(input logic [11:0] p, input logic [3:0] w);
        logic [3:0] r;
        for (int k = 0; k < 4; k++) begin
            if (!p[k]) r[k] = 1'b0;
            else if (p[8 + k]) r[k] = w[k];
            else r[k] = 1'b1;
        end
        return r;
    endfunction

    // bounded wait for hready at a rising edge
    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                num_errors++;
                complete_run();
            end
            @(posedge hclk);
        end
    endtask

    // one single word transfer, read data taken at the data-phase edge
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask

    // low nibble first, it freezes the high nibble
    task automatic cnt_chk;
        rchk("cnt_low", `OFF_CNT0_LOW, {28'h0, cnt[3:0]});
        rchk("cnt_high", `OFF_CNT0_HIGH, {28'h0, cnt[7:4]});
    endtask

    // one event-clock pulse; long enough for the one-cycle pin lag
    task automatic fall_edge;
        event_clock_pin <= 1'b1;
        repeat (3) @(posedge hclk);
        chk("level", 32'h1, {31'h0, event_pin_level});
        event_clock_pin <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask

    // free-running bench clock
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // main sequence
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 12'h000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        event_clock_pin = 1'b0;
        num_errors = 0;
        samples_checked = 0;
        void'($urandom(32'h10bea630));
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk("ctrl", `OFF_CTRL, 32'h0);
        rchk("flags", `OFF_IRQ_FLAG, 32'h0);
        chk("oe", 32'hf, {28'h0, port_oe});
        // timer1 on the fast source with the oscillator left off
        // fast oscillator never switched on, so no 5 ms settle wait is owed
        bus(1'b1, `OFF_CTRL, 32'h42);
        repeat (300) @(posedge hclk);
        rchk("status", `OFF_STATUS, 32'h0);
        bus(1'b1, `OFF_CTRL, 32'h0);
        // timer0 on the event pin
        rel = 8'($urandom_range(9, 3));
        cnt = rel;
        bus(1'b1, `OFF_RELOAD0, {24'h0, rel});
        bus(1'b1, `OFF_CTRL, 32'h21);
        rchk("status", `OFF_STATUS, 32'h0);
        fall_edge();
        rchk("status", `OFF_STATUS, 32'h1);
        repeat (2) begin
            cnt_chk();
            fall_edge();
            cnt = cnt - 8'h01;
        end
        bus(1'b1, `OFF_CTRL, 32'h20);
        rchk("ctrl", `OFF_CTRL, 32'h21);
        rchk("status", `OFF_STATUS, 32'h1);
        fall_edge();
        cnt = cnt - 8'h01;
        rchk("status", `OFF_STATUS, 32'h0);
        rchk("ctrl", `OFF_CTRL, 32'h20);
        fall_edge();
        cnt_chk();
        // restart loads, then rel steps to zero, next edge underflows
        bus(1'b1, `OFF_CTRL, 32'h21);
        repeat (rel + 1) fall_edge();
        rchk("flags", `OFF_IRQ_FLAG, 32'h0);
        fall_edge();
        rchk("flags", `OFF_IRQ_FLAG, 32'h1);
        chk("irq", 32'h0, {31'h0, irq});
        bus(1'b1, `OFF_IRQ_MASK, 32'h1);
        repeat (2) @(posedge hclk);
        chk("irq", 32'h1, {31'h0, irq});
        bus(1'b1, `OFF_IRQ_FLAG, 32'h0);
        rchk("flags", `OFF_IRQ_FLAG, 32'h1);
        bus(1'b1, `OFF_IRQ_FLAG, 32'h1);
        rchk("flags", `OFF_IRQ_FLAG, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        bus(1'b1, `OFF_IRQ_MASK, 32'h0);
        // pin control: random plus forced low and forced float
        for (int i = 0; i < 8; i++) begin
            pv = 12'($urandom);
            if (i == 0) pv = 12'hf00;
            if (i == 1) pv[7:4] = 4'hf;
            m = ~pv[7:4];
            bus(1'b1, `OFF_PORT, {20'h0, pv});
            repeat (2) @(posedge hclk);
            chk("oe", {28'h0, ~pv[7:4]}, {28'h0, port_oe});
            chk("out", {28'h0, exp_out(pv, 4'h0) & m}, {28'h0, port_out & m});
            rchk("port", `OFF_PORT, {20'h0, pv});
        end
        // wave enable on: one underflow so far left timer 0's wave high, timer 1's low
        bus(1'b1, `OFF_CTRL, 32'h25);
        bus(1'b1, `OFF_PORT, 32'h30f);
        repeat (2) @(posedge hclk);
        chk("wave", {28'h0, exp_out(12'h30f, 4'h5)}, {28'h0, port_out});
        bus(1'b1, `OFF_PORT, 32'h30e);
        repeat (2) @(posedge hclk);
        chk("wave", {28'h0, exp_out(12'h30e, 4'h5)}, {28'h0, port_out});
        complete_run();
    end
endmodule // dual_down_counting_timer_tb
`default_nettype wire
